//--- ubh_defs.svh
// Constants for the burst handshake: widths, depths and timing counts
`ifndef UBH_DEFS_SVH
`define UBH_DEFS_SVH

// ==========================================================
// Widths and depths
`define UBH_WORD_W 16
`define UBH_ADDR_W 11
`define UBH_IDE_ADDR_W 3
`define UBH_SEL_W 2
`define UBH_DEV_DEPTH 2
`define UBH_HOST_DEPTH 8
`define UBH_PAUSE_WORDS 3

// ==========================================================
// Timing
`define UBH_CLK_MHZ 250
`define UBH_TRP_NS 160
`define UBH_TRP_CYC ((`UBH_TRP_NS * `UBH_CLK_MHZ + 999) / 1000)
`define UBH_TRFS_NS 75
`define UBH_TRFS_CYC ((`UBH_TRFS_NS * `UBH_CLK_MHZ) / 1000)
`define UBH_TENV_NS 20
`define UBH_TENV_CYC ((`UBH_TENV_NS * `UBH_CLK_MHZ + 999) / 1000)
`define UBH_STB_HALF 8
`define UBH_TMR_W 8

`endif

//--- ubh_pkg.sv
// Types and shared decode functions of the burst handshake
`include "ubh_defs.svh"

package ubh_pkg;

    // ==========================================================
    // Types
    typedef logic [`UBH_WORD_W-1:0] ubh_word_t;
    typedef logic [`UBH_ADDR_W-1:0] ubh_addr_t;

    typedef enum {
        DEV_IDLE,
        DEV_REQ,
        DEV_BURST,
        DEV_END
    } ubh_dev_state_e;

    typedef enum {
        HST_IDLE,
        HST_ENV,
        HST_BURST,
        HST_PAUSE,
        HST_STOP,
        HST_DONE
    } ubh_host_state_e;

    // ==========================================================
    // Functions
    // Symmetric: maps asserted to pin level and pin level back
    function automatic logic ubh_pin(input logic level, input logic active_high);
        return ~(level ^ active_high);
    endfunction

    // Disk mode uses only the low address lines
    function automatic ubh_addr_t ubh_addr(input logic mode_pc, input ubh_addr_t a);
        ubh_addr_t r;
        r = '0;
        if (mode_pc) begin
            r = a;
        end else begin
            r[`UBH_IDE_ADDR_W-1:0] = a[`UBH_IDE_ADDR_W-1:0];
        end
        return r;
    endfunction

endpackage

//--- ubh_if.sv
// Link between card end and host end of the burst handshake
`timescale 1ns/100ps
`include "ubh_defs.svh"

interface ubh_if;
    logic dmarq;
    logic dmack;
    logic iordy_drv;
    logic iordy_oe;
    logic iordy;
    logic hioe_n;
    logic hiow_n;
    logic [`UBH_WORD_W-1:0] hd;
    logic [`UBH_ADDR_W-1:0] ha;
    logic [`UBH_SEL_W-1:0] sel_n;

    // Host pull-up gives the released line a known high level
    assign iordy = iordy_oe ? iordy_drv : 1'b1;

    modport dev (
        output dmarq, iordy_drv, iordy_oe, hd,
        input dmack, hioe_n, hiow_n, ha, sel_n
    );

    modport host (
        output dmack, hioe_n, hiow_n, ha, sel_n,
        input dmarq, iordy, hd
    );
endinterface

//--- ubh_dev.sv
// Card end: sends words on both strobe edges during a data-in burst
`timescale 1ns/100ps
`include "ubh_defs.svh"

module ubh_dev (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Mode
    input wire logic mode_pc_i,
    // Word stream from the card core
    input wire logic in_valid_i,
    input wire ubh_pkg::ubh_word_t in_data_i,
    output logic in_ready_o,
    input wire logic done_i,
    // Burst status
    output logic busy_o,
    output ubh_pkg::ubh_addr_t addr_o,
    output logic [`UBH_SEL_W-1:0] sel_n_o,
    // Link
    ubh_if.dev link
);
    localparam int NS = 3 + `UBH_ADDR_W + `UBH_SEL_W;
    localparam logic [3:0] PH_LAST = 4'(`UBH_STB_HALF - 1);
    localparam logic [3:0] PH_EDGE = 4'(`UBH_STB_HALF / 2);

    // ==========================================================
    // Input synchronisers
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    wire [NS-1:0] raw = {link.dmack, link.hioe_n, link.hiow_n, link.ha, link.sel_n};

    for (genvar i = 0; i < NS; i++) begin : g_sync
        always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                s1[i] <= 1'b1;
                s2[i] <= 1'b1;
            end else begin
                s1[i] <= raw[i];
                s2[i] <= s1[i];
            end
        end
    end

    wire ack = ubh_pkg::ubh_pin(s2[NS-1], mode_pc_i);
    wire rdy = ~s2[NS-2];
    wire stop = s2[NS-3];
    wire ubh_pkg::ubh_addr_t ha_s = s2[`UBH_SEL_W +: `UBH_ADDR_W];
    wire [`UBH_SEL_W-1:0] sel_s = s2[`UBH_SEL_W-1:0];

    // ==========================================================
    // Two-entry buffer
    ubh_pkg::ubh_word_t mem [`UBH_DEV_DEPTH];
    logic wp;
    logic rp;
    logic [1:0] cnt;
    logic pend;
    logic [3:0] ph;
    ubh_pkg::ubh_dev_state_e st;
    ubh_pkg::ubh_dev_state_e next_st;

    wire buf_empty = (cnt == 2'h0);
    wire push = in_valid_i & in_ready_o;
    // Lines carry burst meaning only with request and acknowledge up
    wire in_burst = (st == ubh_pkg::DEV_BURST) & ack;
    // New words start only while ready is seen, so the last edge
    // lands well inside the final-strobe limit
    wire pop = in_burst & rdy & ~stop & ~pend & (ph == 4'h0) & ~buf_empty;
    wire toggle = pend & (ph == PH_EDGE);
    wire term = ~pend & (stop | ~ack | (done_i & buf_empty));
    wire [1:0] next_cnt = cnt + {1'b0, push} - {1'b0, pop};

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wp] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wp <= 1'b0;
            rp <= 1'b0;
            cnt <= 2'h0;
            in_ready_o <= 1'b0;
        end else begin
            wp <= wp ^ push;
            rp <= rp ^ pop;
            cnt <= next_cnt;
            in_ready_o <= (next_cnt < 2'(`UBH_DEV_DEPTH));
        end
    end

    // ==========================================================
    // Burst sequencing
    always_comb begin
        next_st = st;
        case (st)
            ubh_pkg::DEV_IDLE: begin
                if (!buf_empty && !ack) begin
                    next_st = ubh_pkg::DEV_REQ;
                end
            end
            ubh_pkg::DEV_REQ: begin
                if (ack) begin
                    next_st = ubh_pkg::DEV_BURST;
                end
            end
            ubh_pkg::DEV_BURST: begin
                if (term) begin
                    next_st = ubh_pkg::DEV_END;
                end
            end
            ubh_pkg::DEV_END: begin
                if (!ack) begin
                    next_st = ubh_pkg::DEV_IDLE;
                end
            end
            default: begin
                next_st = ubh_pkg::DEV_IDLE;
            end
        endcase
    end

    wire next_req = (next_st == ubh_pkg::DEV_REQ) | (next_st == ubh_pkg::DEV_BURST);
    wire enter = (st == ubh_pkg::DEV_REQ) & ack;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= ubh_pkg::DEV_IDLE;
            ph <= 4'h0;
            pend <= 1'b0;
        end else begin
            st <= next_st;
            ph <= (!in_burst || ph == PH_LAST) ? 4'h0 : ph + 4'h1;
            pend <= (pend & ~toggle) | pop;
        end
    end

    // ==========================================================
    // Link outputs
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            link.dmarq <= 1'b0;
            link.iordy_oe <= 1'b0;
            link.iordy_drv <= 1'b1;
            link.hd <= '0;
        end else begin
            link.dmarq <= ubh_pkg::ubh_pin(next_req, ~mode_pc_i);
            // Driven from burst entry, released once back to idle
            link.iordy_oe <= (next_st == ubh_pkg::DEV_BURST) | (next_st == ubh_pkg::DEV_END);
            if (next_st == ubh_pkg::DEV_IDLE) begin
                link.iordy_drv <= 1'b1;
            end else if (toggle) begin
                link.iordy_drv <= ~link.iordy_drv;
            end
            if (pop) begin
                link.hd <= mem[rp];
            end
        end
    end

    // ==========================================================
    // Status
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_o <= 1'b0;
            addr_o <= '0;
            sel_n_o <= '1;
        end else begin
            busy_o <= (next_st != ubh_pkg::DEV_IDLE);
            if (enter) begin
                addr_o <= ubh_pkg::ubh_addr(mode_pc_i, ha_s);
                sel_n_o <= sel_s;
            end
        end
    end
endmodule

//--- ubh_host.sv
// Host end: acknowledges bursts, paces with ready, pauses and stops
//
// Contract
// - Stop only after ready-to-pause since ready dropped
// - Up to three words after ready drop
// - Lines take burst roles only with both handshakes
// - Burst roles end once request, acknowledge drop
// - Request, acknowledge polarity follows interface mode
// - Disk mode: three address lines; card: eleven
// - Host pull-up holds released ready line high
// - Recipient waits ready-to-pause before pausing
// - Sender stops strobing within final-strobe limit
`timescale 1ns/100ps
`include "ubh_defs.svh"

module ubh_host #(
    parameter int DEPTH = `UBH_HOST_DEPTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Mode
    input wire logic mode_pc_i,
    // Control from the host core
    input wire logic en_i,
    input wire logic stop_req_i,
    input wire ubh_pkg::ubh_addr_t addr_i,
    input wire logic [`UBH_SEL_W-1:0] sel_n_i,
    // Received word stream
    output logic out_valid_o,
    output ubh_pkg::ubh_word_t out_data_o,
    input wire logic out_ready_i,
    // Status
    output logic busy_o,
    // Link
    ubh_if.host link
);
    localparam int NS = 2 + `UBH_WORD_W;
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
    // Room must stay for the words still in flight after a pause
    localparam logic [AW:0] ROOM_C = (AW + 1)'(DEPTH - `UBH_PAUSE_WORDS);
    localparam logic [`UBH_TMR_W-1:0] TRP_C = `UBH_TMR_W'(`UBH_TRP_CYC - 1);
    localparam logic [`UBH_TMR_W-1:0] TENV_C = `UBH_TMR_W'(`UBH_TENV_CYC - 1);
    localparam logic [`UBH_TMR_W-1:0] TMR_MAX = '1;

    // ==========================================================
    // Input synchronisers
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    logic [NS-1:0] s3;
    wire [NS-1:0] raw = {link.dmarq, link.iordy, link.hd};

    for (genvar i = 0; i < NS; i++) begin : g_sync
        always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                s1[i] <= 1'b1;
                s2[i] <= 1'b1;
            end else begin
                s1[i] <= raw[i];
                s2[i] <= s1[i];
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s3 <= '1;
        end else begin
            s3 <= s2;
        end
    end

    wire req = ubh_pkg::ubh_pin(s2[NS-1], ~mode_pc_i);
    wire req_old = ubh_pkg::ubh_pin(s3[NS-1], ~mode_pc_i);
    // Two samples filter the single-cycle reset level of the request
    wire req_ok = req & req_old;
    wire stb_edge = s2[NS-2] ^ s3[NS-2];
    wire ubh_pkg::ubh_word_t word = s2[`UBH_WORD_W-1:0];

    // ==========================================================
    // Receive buffer
    ubh_pkg::ubh_word_t mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [`UBH_TMR_W-1:0] tmr;
    ubh_pkg::ubh_host_state_e st;
    ubh_pkg::ubh_host_state_e next_st;

    wire acked = (st == ubh_pkg::HST_ENV) | (st == ubh_pkg::HST_BURST)
               | (st == ubh_pkg::HST_PAUSE) | (st == ubh_pkg::HST_STOP);
    // Strobe edges count only while both handshakes are up
    wire cap = stb_edge & req & acked;
    // Full never happens with the room margin; guard keeps pointers sane
    wire push = cap & (cnt != DEPTH_C);
    wire pop = (cnt != '0) & (~out_valid_o | out_ready_i);
    wire room = (cnt < ROOM_C);
    wire [AW:0] next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wp] <= word;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            wp <= push ? wp + 1'b1 : wp;
            rp <= pop ? rp + 1'b1 : rp;
            cnt <= next_cnt;
        end
    end

    // Output stage so the user side sees a registered word
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out_valid_o <= 1'b0;
            out_data_o <= '0;
        end else begin
            if (pop) begin
                out_valid_o <= 1'b1;
                out_data_o <= mem[rp];
            end else if (out_ready_i) begin
                out_valid_o <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Burst sequencing
    always_comb begin
        next_st = st;
        case (st)
            ubh_pkg::HST_IDLE: begin
                if (en_i && req_ok) begin
                    next_st = ubh_pkg::HST_ENV;
                end
            end
            ubh_pkg::HST_ENV: begin
                if (!req) begin
                    next_st = ubh_pkg::HST_DONE;
                end else if (tmr >= TENV_C) begin
                    next_st = ubh_pkg::HST_BURST;
                end
            end
            ubh_pkg::HST_BURST: begin
                if (!req) begin
                    next_st = ubh_pkg::HST_DONE;
                end else if (stop_req_i) begin
                    next_st = ubh_pkg::HST_PAUSE;
                end
            end
            ubh_pkg::HST_PAUSE: begin
                if (!req) begin
                    next_st = ubh_pkg::HST_DONE;
                end else if (tmr >= TRP_C) begin
                    next_st = ubh_pkg::HST_STOP;
                end
            end
            ubh_pkg::HST_STOP: begin
                if (!req) begin
                    next_st = ubh_pkg::HST_DONE;
                end
            end
            ubh_pkg::HST_DONE: begin
                next_st = ubh_pkg::HST_IDLE;
            end
            default: begin
                next_st = ubh_pkg::HST_IDLE;
            end
        endcase
    end

    wire tmr_run = (tmr != TMR_MAX);
    wire next_ack = (next_st == ubh_pkg::HST_ENV) | (next_st == ubh_pkg::HST_BURST)
                  | (next_st == ubh_pkg::HST_PAUSE) | (next_st == ubh_pkg::HST_STOP);
    // Ready only in the open burst and only with room for the tail
    wire next_rdy = (next_st == ubh_pkg::HST_BURST) & room;
    // Outside a burst the write line rests at its inactive high level
    wire next_wr_n = ~((next_st == ubh_pkg::HST_ENV) | (next_st == ubh_pkg::HST_BURST)
                  | (next_st == ubh_pkg::HST_PAUSE));

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= ubh_pkg::HST_IDLE;
            tmr <= '0;
        end else begin
            st <= next_st;
            if (next_st != st) begin
                tmr <= '0;
            end else if (tmr_run) begin
                tmr <= tmr + 1'b1;
            end
        end
    end

    // ==========================================================
    // Link outputs
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            link.dmack <= 1'b1;
            link.hioe_n <= 1'b1;
            link.hiow_n <= 1'b1;
            link.ha <= '0;
            link.sel_n <= '1;
            busy_o <= 1'b0;
        end else begin
            link.dmack <= ubh_pkg::ubh_pin(next_ack, mode_pc_i);
            link.hioe_n <= ~next_rdy;
            link.hiow_n <= next_wr_n;
            link.ha <= ubh_pkg::ubh_addr(mode_pc_i, addr_i);
            link.sel_n <= sel_n_i;
            busy_o <= (next_st != ubh_pkg::HST_IDLE);
        end
    end
endmodule

//--- ubh_monitor.sv
// Assertion checker for the link between card end and host end
`timescale 1ns/100ps
`include "ubh_defs.svh"

module ubh_monitor (
    // Clock, reset and mode
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic mode_pc_i,
    // Link signals
    input wire logic dmarq,
    input wire logic dmack,
    input wire logic iordy_drv,
    input wire logic iordy_oe,
    input wire logic iordy,
    input wire logic hioe_n,
    input wire logic hiow_n,
    input wire logic [`UBH_WORD_W-1:0] hd,
    input wire logic [`UBH_ADDR_W-1:0] ha,
    input wire logic [`UBH_SEL_W-1:0] sel_n
);
    localparam int TRP_CYC = `UBH_TRP_CYC;
    localparam int TRFS_CYC = `UBH_TRFS_CYC;

    // ==========================================================
    // Decode and helpers
    logic prev_drv;
    logic [7:0] off_cnt;
    logic [3:0] late_cnt;
    wire req_on;
    wire ack_on;
    wire stb_edge;
    wire [7:0] next_off_cnt;
    wire [3:0] next_late_cnt;

    // Asserted levels swap with the interface mode
    assign req_on = (dmarq == ~mode_pc_i);
    assign ack_on = (dmack == mode_pc_i);
    // Return to the pull-up on release is not a strobe edge
    assign stb_edge = iordy_oe & (iordy_drv ^ prev_drv);
    // Cycles since host ready went away, saturating
    assign next_off_cnt = !hioe_n ? 8'h00 : (off_cnt == 8'hff ? off_cnt : off_cnt + 8'h01);
    assign next_late_cnt = (!hioe_n || !ack_on) ? 4'h0 :
                           ((stb_edge && late_cnt != 4'hf) ? late_cnt + 4'h1 : late_cnt);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prev_drv <= 1'b1;
            off_cnt <= 8'h00;
            late_cnt <= 4'h0;
        end else begin
            prev_drv <= iordy_drv;
            off_cnt <= next_off_cnt;
            late_cnt <= next_late_cnt;
        end
    end

    // ==========================================================
    // Properties
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_ack_rise;
        $rose(ack_on) && $stable(mode_pc_i);
    endsequence
    sequence s_env_wait;
        hioe_n [*5];
    endsequence
    sequence s_stop_rise;
        ack_on && $rose(hiow_n);
    endsequence

    property p_env;
        s_ack_rise |-> s_env_wait;
    endproperty
    property p_ack_req;
        s_ack_rise |-> req_on && $past(req_on, 2);
    endproperty
    property p_req_end;
        $fell(req_on) && $stable(mode_pc_i) |-> ##[1:8] !ack_on;
    endproperty
    property p_lines;
        (!hioe_n || !hiow_n) |-> ack_on;
    endproperty
    property p_stb_burst;
        stb_edge |-> req_on && ack_on;
    endproperty
    property p_hold;
        stb_edge |-> hd == $past(hd, 3) ##1 $stable(hd);
    endproperty
    property p_stop_rp;
        s_stop_rise |-> off_cnt >= TRP_CYC;
    endproperty
    property p_rfs;
        stb_edge |-> off_cnt <= TRFS_CYC;
    endproperty
    property p_three;
        late_cnt <= 4'h3;
    endproperty
    property p_addr;
        !mode_pc_i && !$past(mode_pc_i) |-> ha[`UBH_ADDR_W-1:3] == 8'h00;
    endproperty

    a_env: assert property (p_env) else $error("ready before envelope time");
    a_ack_req: assert property (p_ack_req) else $error("ack without request");
    a_req_end: assert property (p_req_end) else $error("ack held after request end");
    a_lines: assert property (p_lines) else $error("burst line active outside burst");
    a_stb_burst: assert property (p_stb_burst) else $error("strobe outside burst");
    a_hold: assert property (p_hold) else $error("data moved around strobe");
    a_stop_rp: assert property (p_stop_rp) else $error("stop too soon after pause");
    a_rfs: assert property (p_rfs) else $error("strobe after final limit");
    a_three: assert property (p_three) else $error("too many words after pause");
    a_addr: assert property (p_addr) else $error("high address in disk mode");
endmodule

//--- tb_udma_burst_handshake.sv
// Self-checking bench joining card end and host end over the link
`timescale 1ns/100ps
`include "ubh_defs.svh"

module tb_udma_burst_handshake;
    // ==========================================================
    // Signals
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic mode_pc_i = 1'b0;
    logic in_valid_i = 1'b0;
    ubh_pkg::ubh_word_t in_data_i = '0;
    logic in_ready_o;
    logic done_i = 1'b0;
    logic dev_busy;
    ubh_pkg::ubh_addr_t dev_addr;
    logic [`UBH_SEL_W-1:0] dev_sel_n;
    logic en_i = 1'b0;
    logic stop_req_i = 1'b0;
    ubh_pkg::ubh_addr_t addr_i = '0;
    logic [`UBH_SEL_W-1:0] sel_n_i = '1;
    logic out_valid_o;
    ubh_pkg::ubh_word_t out_data_o;
    logic out_ready_i = 1'b0;
    logic host_busy;
    int fail_count = 0;
    int n_compared = 0;
    ubh_pkg::ubh_word_t rx[$];

    `define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
        $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end

    always #2 clk_i = ~clk_i;

    // ==========================================================
    // Design
    ubh_if ubh_if_i();
    ubh_dev ubh_dev_i (.clk_i(clk_i), .resetn_i(resetn_i), .mode_pc_i(mode_pc_i),
        .in_valid_i(in_valid_i), .in_data_i(in_data_i), .in_ready_o(in_ready_o),
        .done_i(done_i), .busy_o(dev_busy), .addr_o(dev_addr), .sel_n_o(dev_sel_n),
        .link(ubh_if_i.dev));
    ubh_host #(.DEPTH(8)) ubh_host_i (.clk_i(clk_i), .resetn_i(resetn_i),
        .mode_pc_i(mode_pc_i), .en_i(en_i), .stop_req_i(stop_req_i), .addr_i(addr_i),
        .sel_n_i(sel_n_i), .out_valid_o(out_valid_o), .out_data_o(out_data_o),
        .out_ready_i(out_ready_i), .busy_o(host_busy), .link(ubh_if_i.host));
    ubh_monitor ubh_monitor_i (.clk_i(clk_i), .resetn_i(resetn_i), .mode_pc_i(mode_pc_i),
        .dmarq(ubh_if_i.dmarq), .dmack(ubh_if_i.dmack), .iordy_drv(ubh_if_i.iordy_drv),
        .iordy_oe(ubh_if_i.iordy_oe), .iordy(ubh_if_i.iordy), .hioe_n(ubh_if_i.hioe_n),
        .hiow_n(ubh_if_i.hiow_n), .hd(ubh_if_i.hd), .ha(ubh_if_i.ha), .sel_n(ubh_if_i.sel_n));

    always @(posedge clk_i) begin
        if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
            rx.push_back(out_data_o);
        end
    end

    // ==========================================================
    // Tasks
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Returns just after an edge, so drives stay off the sampling edge
    task automatic wait_rx(input int k);
        int t;
        t = 0;
        do begin
            @(posedge clk_i);
            #1;
        end while (rx.size() < k && ++t < 20000);
        if (rx.size() < k) begin
            fail_count++;
        end
    endtask

    task automatic run_burst(input string name, input logic pc, input int n, input int stall,
                             input int stop, input ubh_pkg::ubh_addr_t a,
                             input logic [`UBH_SEL_W-1:0] s);
        int i;
        int t;
        ubh_pkg::ubh_addr_t ea;
        ea = pc ? a : (a & 11'h007);
        rx.delete();
        mode_pc_i = pc;
        addr_i = a;
        sel_n_i = s;
        out_ready_i = 1'b1;
        // Idle pins settle to the new mode before acking is allowed
        repeat (4) @(posedge clk_i);
        #1 en_i = 1'b1;
        fork
            begin
                for (i = 0; i < n; i++) begin
                    in_valid_i = 1'b1;
                    in_data_i = 16'h1234 + 16'(i);
                    do @(posedge clk_i); while (in_ready_o !== 1'b1);
                    #1;
                end
                in_valid_i = 1'b0;
                done_i = 1'b1;
            end
            begin
                if (stall > 0) begin
                    wait_rx(stall);
                    out_ready_i = 1'b0;
                    repeat (300) @(posedge clk_i);
                    #1 out_ready_i = 1'b1;
                end
                if (stop > 0) begin
                    wait_rx(stop);
                    stop_req_i = 1'b1;
                    t = 0;
                    do begin
                        @(posedge clk_i);
                        #1;
                    end while (host_busy !== 1'b0 && ++t < 5000);
                    if (host_busy !== 1'b0) begin
                        fail_count++;
                    end
                    stop_req_i = 1'b0;
                end
            end
        join
        wait_rx(n);
        repeat (40) @(posedge clk_i);
        `CHK(rx.size(), n)
        for (i = 0; i < n && i < rx.size(); i++) begin
            `CHK(rx[i], 16'h1234 + 16'(i))
        end
        `CHK(dev_addr, ea)
        `CHK(ubh_if_i.ha, ea)
        `CHK(dev_sel_n, s)
        `CHK(ubh_if_i.dmarq, pc)
        `CHK(ubh_if_i.dmack, ~pc)
        `CHK({ubh_if_i.hioe_n, ubh_if_i.hiow_n}, 2'b11)
        `CHK(ubh_if_i.iordy, 1'b1)
        `CHK({dev_busy, host_busy}, 2'b00)
        #1 done_i = 1'b0;
        en_i = 1'b0;
        $display("test %s done", name);
    endtask

    // Odd word count ends on a low strobe
    task automatic test_disk_odd();
        run_burst("disk_odd", 1'b0, 7, 0, 0, 11'h5ad, 2'b10);
    endtask

    task automatic test_card_full_addr();
        run_burst("card_addr", 1'b1, 10, 0, 0, 11'h7ff, 2'b01);
    endtask

    // Receiver stall fills the host buffer up to its room margin and forces a pause
    task automatic test_stall();
        run_burst("stall", 1'b0, 24, 4, 0, 11'h3f2, 2'b01);
    endtask

    // Stop mid burst; the rest must arrive in a later burst
    task automatic test_stop();
        run_burst("stop", 1'b1, 24, 0, 6, 11'h123, 2'b10);
    endtask

    // ==========================================================
    // Sequence
    initial begin
        repeat (10) @(posedge clk_i);
        #1 resetn_i = 1'b1;
        test_disk_odd();
        test_card_full_addr();
        test_stall();
        test_stop();
        conclude();
    end

    initial begin
        #200000;
        fail_count++;
        conclude();
    end
endmodule
